// ==== src/pcfr_core.sv ====
// Purpose: next fetch pointer and flag register of an 8-bit core
// Assumes: decode pulses are one cycle; inputs synchronous to CLK
// Notes:   reset vector is fetched in two bus reads after reset
`include "pcfr_regs.svh"

module pcfr_core
    import pcfr_pkg::*;
(
    input  wire logic          CLK,
    input  wire logic          SRST,
    input  wire logic          FETCH,
    input  wire logic          FLOW_LOAD,
    input  wire logic [15:0]   FLOW_TARGET,
    input  wire logic [7:0]    MEM_RDATA,
    input  wire logic          INSN_END,
    input  wire logic          IRQ_PENDING,
    input  wire logic          IRQ_ENTRY,
    input  wire logic          MASK_SET,
    input  wire logic          MASK_CLEAR,
    input  wire logic          ACC_TO_FLAGS,
    input  wire logic [7:0]    ACC,
    input  wire logic          RETI_START,
    input  wire logic [7:0]    STACKED_FLAGS,
    input  wire logic          LOW_POWER,
    input  wire pcfr_alu_req_t ALU_REQ,
    input  wire pcfr_cond_t    BR_COND,
    output logic [15:0]        FETCH_ADDR,
    output logic               VEC_BUSY,
    output logic [7:0]         FLAGS,
    output logic [7:0]         FLAGS_TO_STACK,
    output logic               IRQ_TAKE
);
    logic [15:0] pc_q;
    logic [7:0]  flags_q;
    logic [1:0]  vec_q;
    logic        mask_d;
    logic        busy_q;
    logic        hold_q;
    logic [7:0]  vec_lo_q;
    logic [7:0]  stk_q;
    logic        take_q;
    logic        alu_v, alu_n, alu_z, alu_c, alu_h;
    logic [16:0] alu_res;
    logic        br_take;

    function automatic logic [7:0] pcfr_fix(input logic [7:0] v);
        pcfr_fix = v | `PCFR_FIXED_ONES;
    endfunction

    // ALU flag evaluation
    always_comb begin
        logic sa, sb, sr;
        sa = 1'b0;
        sb = 1'b0;
        sr = 1'b0;
        alu_h = 1'b0;
        if (ALU_REQ.op == PCFR_ALU_ADD) begin
            alu_res = {1'b0, ALU_REQ.reg_opnd} + {1'b0, ALU_REQ.mem_opnd}
                    + {16'h0000, ALU_REQ.carry_in};
            alu_h = ALU_REQ.reg_opnd[4] ^ ALU_REQ.mem_opnd[4]
                  ^ alu_res[4];
        end else begin
            alu_res = {1'b0, ALU_REQ.reg_opnd} - {1'b0, ALU_REQ.mem_opnd}
                    - {16'h0000, ALU_REQ.carry_in};
        end
        if (ALU_REQ.wide) begin
            sa = ALU_REQ.reg_opnd[15];
            sb = ALU_REQ.mem_opnd[15];
            sr = alu_res[15];
            alu_z = (alu_res[15:0] == 16'h0000);
            alu_c = alu_res[16];
        end else begin
            sa = ALU_REQ.reg_opnd[7];
            sb = ALU_REQ.mem_opnd[7];
            sr = alu_res[7];
            alu_z = (alu_res[7:0] == 8'h00);
            alu_c = ALU_REQ.reg_opnd[8] ^ ALU_REQ.mem_opnd[8] ^ alu_res[8];
        end
        alu_n = sr;
        if (ALU_REQ.op == PCFR_ALU_ADD) begin
            alu_v = (sa == sb) && (sr != sa);
        end else begin
            alu_v = (sa != sb) && (sr != sa);
        end
    end

    // Branch condition decode
    always_comb begin
        logic c, z, n, v, h;
        c = flags_q[`PCFR_BIT_C];
        z = flags_q[`PCFR_BIT_Z];
        n = flags_q[`PCFR_BIT_N];
        v = flags_q[`PCFR_BIT_V];
        h = flags_q[`PCFR_BIT_H];
        unique case (BR_COND)
            PCFR_BR_ALWAYS: br_take = 1'b1;
            PCFR_BR_NEVER:  br_take = 1'b0;
            PCFR_BR_CC:     br_take = !c;
            PCFR_BR_CS:     br_take = c;
            PCFR_BR_NE:     br_take = !z;
            PCFR_BR_EQ:     br_take = z;
            PCFR_BR_PL:     br_take = !n;
            PCFR_BR_MI:     br_take = n;
            PCFR_BR_HCC:    br_take = !h;
            PCFR_BR_HCS:    br_take = h;
            PCFR_BR_LT:     br_take = n ^ v;
            PCFR_BR_GE:     br_take = !(n ^ v);
            PCFR_BR_LE:     br_take = z | (n ^ v);
            PCFR_BR_GT:     br_take = !(z | (n ^ v));
            PCFR_BR_LS:     br_take = c | z;
            PCFR_BR_HI:     br_take = !(c | z);
        endcase
    end

    // Reset vector fetch sequencer, low byte then high byte
    always_ff @(posedge CLK) begin
        if (SRST) begin
            vec_q <= 2'd2;
        end else if (vec_q != 2'd0) begin
            vec_q <= vec_q - 2'd1;
        end
    end

    // Busy flag kept as a register so the output comes from a flop
    always_ff @(posedge CLK) begin
        if (SRST) begin
            busy_q <= 1'b1;
        end else if (vec_q == 2'd1) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            vec_lo_q <= 8'h00;
        end else if (vec_q == 2'd2) begin
            vec_lo_q <= MEM_RDATA;
        end
    end

    // Fetch pointer; the block core waits while the vector loads
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pc_q <= `PCFR_RST_VEC_LO;
        end else if (vec_q == 2'd2) begin
            pc_q <= `PCFR_RST_VEC_HI;
        end else if (vec_q == 2'd1) begin
            pc_q <= {MEM_RDATA, vec_lo_q};
        end else if (FLOW_LOAD) begin
            pc_q <= FLOW_TARGET;
        end else if (FETCH) begin
            pc_q <= pc_q + 16'h0001;
        end
    end

    // Next mask value; entry wins so the stacked copy keeps the old mask
    always_comb begin
        mask_d = flags_q[`PCFR_BIT_I];
        if (IRQ_ENTRY) begin
            mask_d = 1'b1;
        end else if (LOW_POWER) begin
            mask_d = 1'b0;
        end else if (RETI_START) begin
            mask_d = STACKED_FLAGS[`PCFR_BIT_I];
        end else if (ACC_TO_FLAGS) begin
            mask_d = ACC[`PCFR_BIT_I];
        end else if (MASK_SET) begin
            mask_d = 1'b1;
        end else if (MASK_CLEAR) begin
            mask_d = 1'b0;
        end
    end

    // Flag register; status bits keep their value through reset
    always_ff @(posedge CLK) begin
        if (RETI_START) begin
            flags_q[7] <= STACKED_FLAGS[7];
            flags_q[4] <= STACKED_FLAGS[4];
            flags_q[2:0] <= STACKED_FLAGS[2:0];
        end else if (ACC_TO_FLAGS) begin
            flags_q[7] <= ACC[7];
            flags_q[4] <= ACC[4];
            flags_q[2:0] <= ACC[2:0];
        end else if (ALU_REQ.op != PCFR_ALU_NONE) begin
            flags_q[`PCFR_BIT_V] <= alu_v;
            flags_q[`PCFR_BIT_N] <= alu_n;
            flags_q[`PCFR_BIT_Z] <= alu_z;
            flags_q[`PCFR_BIT_C] <= alu_c;
            if (ALU_REQ.op == PCFR_ALU_ADD) begin
                flags_q[`PCFR_BIT_H] <= alu_h;
            end
        end
        flags_q[6:5] <= 2'b11;
        if (SRST) begin
            flags_q[`PCFR_BIT_I] <= 1'b1;
        end else begin
            flags_q[`PCFR_BIT_I] <= mask_d;
        end
    end

    // Stacked copy taken before the mask is set
    always_ff @(posedge CLK) begin
        if (SRST) begin
            stk_q <= `PCFR_RST_FLAGS;
        end else if (!IRQ_ENTRY) begin
            stk_q <= pcfr_fix(flags_q);
        end
    end

    // A clear at a boundary protects one more instruction
    always_ff @(posedge CLK) begin
        if (SRST) begin
            hold_q <= 1'b0;
        end else if (INSN_END) begin
            hold_q <= (MASK_CLEAR | ACC_TO_FLAGS)
                    & flags_q[`PCFR_BIT_I] & !mask_d;
        end else if (LOW_POWER) begin
            hold_q <= 1'b0;
        end
    end

    // Old mask governs the boundary, so a late set lets one through
    always_ff @(posedge CLK) begin
        if (SRST) begin
            take_q <= 1'b0;
        end else begin
            take_q <= INSN_END & IRQ_PENDING & !flags_q[`PCFR_BIT_I]
                    & !hold_q & !LOW_POWER
                    & !busy_q;
        end
    end

    assign FETCH_ADDR = pc_q;
    assign VEC_BUSY = busy_q;
    assign FLAGS = pcfr_fix(flags_q);
    assign FLAGS_TO_STACK = stk_q;
    assign IRQ_TAKE = take_q;

    // Branch decision, registered for the assertions only; no output port carries it
    logic br_take_q;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            br_take_q <= 1'b0;
        end else begin
            br_take_q <= br_take;
        end
    end

    a_mask_reset: assert property (@(posedge CLK)
        SRST |=> FLAGS[`PCFR_BIT_I])
        else $error("mask not set after reset");
    a_fixed_ones: assert property (@(posedge CLK) disable iff (SRST)
        FLAGS[6:5] == 2'b11)
        else $error("fixed flag bits not one");
    a_pc_step: assert property (@(posedge CLK) disable iff (SRST)
        (vec_q == 2'd0 && FETCH && !FLOW_LOAD)
        |=> FETCH_ADDR == $past(FETCH_ADDR) + 16'h0001)
        else $error("fetch pointer did not step");
    a_flow_load: assert property (@(posedge CLK) disable iff (SRST)
        (vec_q == 2'd0 && FLOW_LOAD) |=> FETCH_ADDR == $past(FLOW_TARGET))
        else $error("flow target not loaded");
    sequence s_vec_fetch;
        (FETCH_ADDR == `PCFR_RST_VEC_LO)
        ##1 (!SRST && FETCH_ADDR == `PCFR_RST_VEC_HI);
    endsequence
    a_vec_order: assert property (@(posedge CLK)
        (SRST ##1 !SRST) |-> s_vec_fetch)
        else $error("reset vector order wrong");
    a_mask_block: assert property (@(posedge CLK) disable iff (SRST)
        (INSN_END && FLAGS[`PCFR_BIT_I]) |=> !IRQ_TAKE)
        else $error("interrupt taken while masked");
    a_entry_mask: assert property (@(posedge CLK) disable iff (SRST)
        IRQ_ENTRY |=> FLAGS[`PCFR_BIT_I])
        else $error("entry did not set mask");
    a_clear_hold: assert property (@(posedge CLK) disable iff (SRST)
        (INSN_END && MASK_CLEAR && FLAGS[`PCFR_BIT_I]) |=> hold_q)
        else $error("interrupt right after mask clear");
    a_le_branch: assert property (@(posedge CLK) disable iff (SRST)
        BR_COND == PCFR_BR_LE |=> br_take_q == ($past(FLAGS[1])
        | ($past(FLAGS[2]) ^ $past(FLAGS[7]))))
        else $error("less-or-equal decision wrong");
    a_add_ovf: assert property (@(posedge CLK) disable iff (SRST)
        (ALU_REQ.op == PCFR_ALU_ADD && !RETI_START && !ACC_TO_FLAGS)
        |=> FLAGS[7] == $past(alu_v))
        else $error("add overflow not recorded");
endmodule

// ==== src/pcfr_pkg.sv ====
// Purpose: types for the fetch pointer and flag register block
// Assumes: nothing beyond the constants header
// Notes:   branch and ALU op codes are local to this block
package pcfr_pkg;
    typedef enum logic [3:0] {
        PCFR_BR_ALWAYS, PCFR_BR_NEVER, PCFR_BR_CC, PCFR_BR_CS,
        PCFR_BR_NE, PCFR_BR_EQ, PCFR_BR_PL, PCFR_BR_MI,
        PCFR_BR_HCC, PCFR_BR_HCS, PCFR_BR_LT, PCFR_BR_GE,
        PCFR_BR_LE, PCFR_BR_GT, PCFR_BR_LS, PCFR_BR_HI
    } pcfr_cond_t;
    typedef enum logic [1:0] {
        PCFR_ALU_NONE, PCFR_ALU_ADD, PCFR_ALU_SUB
    } pcfr_alu_t;
    typedef struct packed {
        pcfr_alu_t   op;
        logic        wide;
        logic        carry_in;
        logic [15:0] reg_opnd;
        logic [15:0] mem_opnd;
    } pcfr_alu_req_t;
endpackage

// ==== src/pcfr_regs.svh ====
// Purpose: constants for the fetch pointer and flag register block
// Assumes: one core clock, synchronous reset
// Notes:   flag positions follow the usual 8-bit core layout
`ifndef PCFR_REGS_SVH
`define PCFR_REGS_SVH
`define PCFR_RST_VEC_HI   16'hFFFF
`define PCFR_RST_VEC_LO   16'hFFFE
`define PCFR_BIT_C        0
`define PCFR_BIT_Z        1
`define PCFR_BIT_N        2
`define PCFR_BIT_I        3
`define PCFR_BIT_H        4
`define PCFR_BIT_V        7
`define PCFR_FIXED_ONES   8'h60
`define PCFR_RST_FLAGS    8'h68
`endif

// ==== tb/pcfr_mem_model.sv ====
// Purpose: program memory and maskable request source facing the core
// Assumes: vector bytes sit at the two top addresses
// Notes:   other addresses give a moving pattern, never a stale byte
module pcfr_mem_model #(
    parameter logic [15:0] VEC = 16'hC35A
) (
    input  wire logic        CLK,
    input  wire logic [15:0] ADDR,
    input  wire logic        RAISE,
    output logic [7:0]       RDATA,
    output logic             PENDING
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] spin_q = 8'h00;
    always_ff @(posedge CLK) spin_q <= spin_q + 8'h01;
    always_ff @(posedge CLK) PENDING <= RAISE;
    always_comb begin
        case (ADDR)
            16'hFFFE: RDATA = VEC[7:0];
            16'hFFFF: RDATA = VEC[15:8];
            default:  RDATA = spin_q;
        endcase
    end
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for fetch pointer and flag register
// Assumes: inputs change by NBA at rise, outputs read at fall
// Notes:   status flags unknown after reset, so ALU checks come first
module tb_top
    import pcfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] VEC = 16'hC35A;
    logic          clk = 1'b0;
    logic          srst = 1'b1;
    logic          fetch = 1'b0;
    logic          flow = 1'b0;
    logic [15:0]   target = 16'h0000;
    logic [5:0]    ctl = 6'h00;
    logic          raise = 1'b0;
    logic          tap = 1'b0;
    logic [7:0]    acc = 8'h00;
    logic [7:0]    stk = 8'h93;
    pcfr_alu_req_t alu_req = '0;
    pcfr_cond_t    cond = PCFR_BR_ALWAYS;
    logic [7:0]    rdata;
    logic          pend;
    logic [15:0]   addr;
    logic          busy;
    logic [7:0]    flags;
    logic [7:0]    to_stack;
    logic          take;
    logic [15:0]   n_take = 16'h0000;
    int            n_mismatch = 0;
    int            n_checks = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) if (take === 1'b1) n_take <= n_take + 16'h0001;

    pcfr_mem_model #(.VEC(VEC)) mem_u (.CLK(clk), .ADDR(addr),
        .RAISE(raise), .RDATA(rdata), .PENDING(pend));
    // Control bits: set, clear, boundary, entry, low power, return
    pcfr_core dut_u (.CLK(clk), .SRST(srst), .FETCH(fetch),
        .FLOW_LOAD(flow), .FLOW_TARGET(target), .MEM_RDATA(rdata),
        .INSN_END(ctl[3]), .IRQ_PENDING(pend), .IRQ_ENTRY(ctl[2]),
        .MASK_SET(ctl[5]), .MASK_CLEAR(ctl[4]), .ACC_TO_FLAGS(tap),
        .ACC(acc), .RETI_START(ctl[0]), .STACKED_FLAGS(stk),
        .LOW_POWER(ctl[1]), .ALU_REQ(alu_req), .BR_COND(cond),
        .FETCH_ADDR(addr), .VEC_BUSY(busy), .FLAGS(flags),
        .FLAGS_TO_STACK(to_stack), .IRQ_TAKE(take));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ctl_pulse(input logic [5:0] v, input int n);
        @(posedge clk);
        ctl <= v;
        @(posedge clk);
        ctl <= 6'h00;
        repeat (n) @(negedge clk);
    endtask

    task automatic alu(input pcfr_alu_t op, input logic w, input logic c,
                       input logic [15:0] r, input logic [15:0] m,
                       input logic [7:0] e, input logic [7:0] mk);
        @(posedge clk);
        alu_req <= '{op, w, c, r, m};
        @(posedge clk);
        alu_req <= '0;
        @(negedge clk);
        chk({8'h00, flags & mk}, {8'h00, e & mk});
    endtask

    task automatic tfr(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        tap <= 1'b1;
        acc <= a;
        @(posedge clk);
        tap <= 1'b0;
        @(negedge clk);
        chk({8'h00, flags}, {8'h00, e});
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        tally_and_finish;
    end

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(addr, 16'hFFFE);
        chk({15'h0000, flags[3]}, 16'h0001);
        chk({14'h0000, flags[6:5]}, 16'h0003);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(addr, VEC);
        chk({15'h0000, busy}, 16'h0000);
        $display("test reset done");
        @(posedge clk);
        fetch <= 1'b1;
        repeat (3) @(posedge clk);
        flow <= 1'b1;
        target <= 16'hFFFF;
        @(negedge clk);
        chk(addr, VEC + 16'h0003);
        @(posedge clk);
        flow <= 1'b0;
        @(negedge clk);
        chk(addr, 16'hFFFF);
        @(posedge clk);
        fetch <= 1'b0;
        @(negedge clk);
        chk(addr, 16'h0000);
        $display("test fetch done");
        // Mask bit is left out here; its own tests follow
        alu(PCFR_ALU_ADD, 1'b0, 1'b0, 16'h0050, 16'h0050, 8'hE4, 8'hF7);
        alu(PCFR_ALU_ADD, 1'b0, 1'b0, 16'h0008, 16'h0008, 8'h70, 8'hF7);
        alu(PCFR_ALU_ADD, 1'b0, 1'b0, 16'h0080, 16'h0080, 8'hE3, 8'hF7);
        alu(PCFR_ALU_SUB, 1'b0, 1'b0, 16'h0080, 16'h0001, 8'hE0, 8'hE7);
        alu(PCFR_ALU_SUB, 1'b0, 1'b0, 16'h0001, 16'h0080, 8'hE5, 8'hE7);
        alu(PCFR_ALU_SUB, 1'b0, 1'b0, 16'h0001, 16'h0002, 8'h65, 8'hE7);
        alu(PCFR_ALU_SUB, 1'b1, 1'b0, 16'h1234, 16'h1234, 8'h62, 8'hE7);
        alu(PCFR_ALU_SUB, 1'b1, 1'b0, 16'h0100, 16'h0001, 8'h60, 8'hE7);
        alu(PCFR_ALU_SUB, 1'b0, 1'b1, 16'h0005, 16'h0005, 8'h65, 8'hE7);
        $display("test alu done");
        @(posedge clk);
        cond <= PCFR_BR_LE;
        tfr(8'h07, 8'h67);
        tfr(8'h00, 8'h60);
        tfr(8'h98, 8'hF8);
        $display("test transfer done");
        @(posedge clk);
        raise <= 1'b1;
        ctl_pulse(6'h08, 3);
        ctl_pulse(6'h08, 3);
        chk(n_take, 16'h0000);
        ctl_pulse(6'h18, 3);
        chk({15'h0000, flags[3]}, 16'h0000);
        ctl_pulse(6'h08, 3);
        chk(n_take, 16'h0000);
        ctl_pulse(6'h08, 3);
        chk(n_take, 16'h0001);
        ctl_pulse(6'h04, 1);
        chk({8'h00, to_stack & 8'h08}, 16'h0000);
        chk({8'h00, flags & 8'h08}, 16'h0008);
        ctl_pulse(6'h08, 3);
        chk(n_take, 16'h0001);
        ctl_pulse(6'h01, 1);
        chk({8'h00, flags}, 16'h00F3);
        @(posedge clk);
        raise <= 1'b0;
        ctl_pulse(6'h08, 3);
        ctl_pulse(6'h08, 3);
        @(posedge clk);
        raise <= 1'b1;
        ctl_pulse(6'h28, 3);
        chk(n_take, 16'h0002);
        ctl_pulse(6'h08, 3);
        chk(n_take, 16'h0002);
        ctl_pulse(6'h0A, 3);
        chk({15'h0000, flags[3]}, 16'h0000);
        chk(n_take, 16'h0002);
        $display("test mask done");
        tally_and_finish;
    end
endmodule
